/* File: pkg/rls_regs.vh */
// constants of the radio link setup register group
// assumes an 8-bit register port with 5-bit register addresses
`ifndef RLS_REGS_VH
`define RLS_REGS_VH

// register addresses
`define RLS_ADDR_AW      5'h03
`define RLS_ADDR_RETX    5'h04
`define RLS_ADDR_CHAN    5'h05
`define RLS_ADDR_RADIO   5'h06

// address width setup field
`define RLS_AW_LSB       0
`define RLS_AW_RST       2'h3
`define RLS_AW_ILLEGAL   2'h0

// retransmit setup fields
`define RLS_DELAY_LSB    4
`define RLS_DELAY_RST    4'h0
`define RLS_COUNT_LSB    0
`define RLS_COUNT_RST    4'h3

// channel field
`define RLS_CHAN_LSB     0
`define RLS_CHAN_RST     7'h02

// radio setup fields
`define RLS_CARRIER_BIT  7
`define RLS_LOWRATE_BIT  5
`define RLS_FORCE_BIT    4
`define RLS_HIGHRATE_BIT 3
`define RLS_POWER_LSB    1
`define RLS_CARRIER_RST  1'h0
`define RLS_LOWRATE_RST  1'h0
`define RLS_FORCE_RST    1'h0
`define RLS_HIGHRATE_RST 1'h1
`define RLS_POWER_RST    2'h3

// data rate codes on rate_select
`define RLS_RATE_1M      2'h0
`define RLS_RATE_2M      2'h1
`define RLS_RATE_250K    2'h2

// retransmit delay step
`define RLS_STEP_US      250
`define RLS_CLK_MHZ      40
// 250 us at 40 MHz, sized for the 18-bit step parameter
`define RLS_STEP_CYCLES  18'd10000

`endif

/* File: hdl/rls_retx_engine.v */
// automatic retransmission sequencer with lost packet counter
// assumes one-cycle event pulses from the transmit state machine
`timescale 1ns/1ps
`default_nettype none

module rls_retx_engine #(
  parameter [17:0] STEP_CYCLES = 18'd10000
) (
  input  wire       clk,
  input  wire       reset,
  input  wire [3:0] delay_code,
  input  wire [3:0] count_code,
  input  wire       ack_required,
  input  wire       new_packet,
  input  wire       tx_end,
  input  wire       ack_received,
  input  wire       ack_failed,
  input  wire       clear_lost,
  output reg        retx_start,
  output reg        retx_exhausted,
  output reg  [3:0] retx_done_count,
  output reg  [3:0] lost_packet_counter
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;

  reg  [1:0]  state;
  reg  [17:0] timer;
  reg         failed;
  wire [17:0] delay_steps = {14'h0, delay_code} + 18'h1;
  wire [35:0] delay_prod  = {18'h0, delay_steps} * {18'h0, STEP_CYCLES};

  always @(posedge clk)
  begin
    if (reset)
    begin
      state               <= ST_IDLE;
      timer               <= 18'h0;
      failed              <= 1'b0;
      retx_start          <= 1'b0;
      retx_exhausted      <= 1'b0;
      retx_done_count     <= 4'h0;
      lost_packet_counter <= 4'h0;
    end
    else
    begin
      retx_start     <= 1'b0;
      retx_exhausted <= 1'b0;
      if (new_packet)
        retx_done_count <= 4'h0;
      case (state)
        ST_IDLE:
        begin
          failed <= 1'b0;
          // RL15 only acked pipes
          if (tx_end && ack_required)
          begin
            // RL4 delay from transmission end
            timer <= delay_prod[17:0] - 18'h1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (timer != 18'h0)
            timer <= timer - 18'h1;
          if (ack_failed)
            failed <= 1'b1;
          if (ack_received)
            state <= ST_IDLE;
          else if (timer == 18'h0 && (failed || ack_failed))
          begin
            state <= ST_IDLE;
            // RL5 bounded retry count
            if (retx_done_count < count_code)
            begin
              retx_start      <= 1'b1;
              retx_done_count <= retx_done_count + 4'h1;
            end
            else
            begin
              retx_exhausted <= 1'b1;
              if (lost_packet_counter != 4'hf)
                lost_packet_counter <= lost_packet_counter + 4'h1;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
      // RL14 channel write clears
      if (clear_lost)
        lost_packet_counter <= 4'h0;
    end
  end

endmodule // rls_retx_engine

`default_nettype wire

/* File: hdl/rls_setup_regs.v */
// radio link setup registers and the logic they steer
// assumes the command port decoder gives one-cycle read/write strobes
// What this block does
// RL1 - Two-bit address width code, resets five bytes
// RL2 - Short widths keep low address bytes only
// RL3 - One address width for every pipe
// RL4 - Retry delay in 250 us steps
// RL5 - Retry count 0 to 15, resets three
// RL6 - Seven-bit channel field, resets to two
// RL7 - Carrier bit makes continuous carrier, resets low
// RL8 - Rate pair selects 1M, 2M, 250k
// RL9 - Low rate overrides high, high resets one
// RL10 - Force bit holds pll lock asserted
// RL11 - Two-bit transmit power, resets to 0 dBm
// RL12 - Access only by command port reads/writes
// RL13 - Undefined bits read back as zero
// RL14 - Channel write clears saturating lost counter
// RL15 - Retries only for auto-acknowledged pipes
// RL16 - Controller writes no reserved or illegal codes
`timescale 1ns/1ps
`default_nettype none
`include "rls_regs.vh"

module rls_setup_regs #(
  parameter [17:0] STEP_CYCLES = `RLS_STEP_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [4:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire [39:0] stored_address,
  input  wire [5:0]  auto_ack_enables,
  input  wire [2:0]  tx_pipe,
  input  wire        tx_mode,
  input  wire        pll_lock_raw,
  input  wire        new_packet,
  input  wire        tx_end,
  input  wire        ack_received,
  input  wire        ack_failed,
  output reg  [39:0] active_address,
  output reg  [2:0]  addr_width_bytes,
  output reg  [6:0]  radio_channel_out,
  output reg         continuous_carrier_out,
  output reg  [1:0]  rate_select,
  output reg         pll_lock_status,
  output reg  [1:0]  tx_power_out,
  output reg         tx_power_enable,
  output wire        retx_start,
  output wire        retx_exhausted,
  output wire [3:0]  retx_done_count,
  output wire [3:0]  lost_packet_counter
);

  // -------------------------------------------------------------
  // register fields
  // -------------------------------------------------------------
  reg  [1:0] addr_width_code;
  reg  [3:0] retransmit_delay;
  reg  [3:0] retransmit_count;
  reg  [6:0] radio_channel;
  reg        continuous_carrier;
  reg        low_rate_select;
  reg        force_lock;
  reg        high_rate_select;
  reg  [1:0] tx_power_level;

  wire       wr_aw    = reg_write && reg_addr == `RLS_ADDR_AW;
  wire       wr_retx  = reg_write && reg_addr == `RLS_ADDR_RETX;
  wire       wr_chan  = reg_write && reg_addr == `RLS_ADDR_CHAN;
  wire       wr_radio = reg_write && reg_addr == `RLS_ADDR_RADIO;
  wire [1:0] new_aw   = reg_wdata[`RLS_AW_LSB +: 2];

  // RL12 writes through command port
  always @(posedge clk)
  begin
    if (reset)
    begin
      // RL1 width resets five bytes
      addr_width_code    <= `RLS_AW_RST;
      // RL4 delay resets shortest
      retransmit_delay   <= `RLS_DELAY_RST;
      // RL5 count resets three
      retransmit_count   <= `RLS_COUNT_RST;
      // RL6 channel resets two
      radio_channel      <= `RLS_CHAN_RST;
      // RL7 carrier resets low
      continuous_carrier <= `RLS_CARRIER_RST;
      low_rate_select    <= `RLS_LOWRATE_RST;
      force_lock         <= `RLS_FORCE_RST;
      // RL9 high rate resets one
      high_rate_select   <= `RLS_HIGHRATE_RST;
      // RL11 power resets 0 dBm
      tx_power_level     <= `RLS_POWER_RST;
    end
    else
    begin
      // RL16 illegal width code ignored
      if (wr_aw && new_aw != `RLS_AW_ILLEGAL)
        addr_width_code <= new_aw;
      if (wr_retx)
      begin
        retransmit_delay <= reg_wdata[`RLS_DELAY_LSB +: 4];
        retransmit_count <= reg_wdata[`RLS_COUNT_LSB +: 4];
      end
      if (wr_chan)
        radio_channel <= reg_wdata[`RLS_CHAN_LSB +: 7];
      if (wr_radio)
      begin
        continuous_carrier <= reg_wdata[`RLS_CARRIER_BIT];
        low_rate_select    <= reg_wdata[`RLS_LOWRATE_BIT];
        force_lock         <= reg_wdata[`RLS_FORCE_BIT];
        high_rate_select   <= reg_wdata[`RLS_HIGHRATE_BIT];
        tx_power_level     <= reg_wdata[`RLS_POWER_LSB +: 2];
      end
    end
  end

  // -------------------------------------------------------------
  // read back
  // -------------------------------------------------------------
  reg [7:0] next_rdata;

  // RL13 undefined bits zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `RLS_ADDR_AW:
        next_rdata[`RLS_AW_LSB +: 2] = addr_width_code;
      `RLS_ADDR_RETX:
      begin
        next_rdata[`RLS_DELAY_LSB +: 4] = retransmit_delay;
        next_rdata[`RLS_COUNT_LSB +: 4] = retransmit_count;
      end
      `RLS_ADDR_CHAN:
        next_rdata[`RLS_CHAN_LSB +: 7] = radio_channel;
      `RLS_ADDR_RADIO:
      begin
        next_rdata[`RLS_CARRIER_BIT]     = continuous_carrier;
        next_rdata[`RLS_LOWRATE_BIT]     = low_rate_select;
        next_rdata[`RLS_FORCE_BIT]       = force_lock;
        next_rdata[`RLS_HIGHRATE_BIT]    = high_rate_select;
        next_rdata[`RLS_POWER_LSB +: 2]  = tx_power_level;
      end
      default:
        next_rdata = 8'h00;
    endcase
  end

  // RL12 reads through command port
  always @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
  end

  // -------------------------------------------------------------
  // address width and address trimming
  // -------------------------------------------------------------
  reg [2:0] next_width;

  // RL1 width code decode
  always @*
  begin
    case (addr_width_code)
      2'h1:    next_width = 3'h3;
      2'h2:    next_width = 3'h4;
      default: next_width = 3'h5;
    endcase
  end

  wire [39:0] next_address;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_byte
      // RL2 keep low bytes
      assign next_address[gi*8 +: 8] =
        (gi < next_width) ? stored_address[gi*8 +: 8] : 8'h00;
    end
  endgenerate

  // RL3 shared width for pipes
  always @(posedge clk)
  begin
    if (reset)
    begin
      addr_width_bytes <= 3'h5;
      active_address   <= 40'h0;
    end
    else
    begin
      addr_width_bytes <= next_width;
      active_address   <= next_address;
    end
  end

  // -------------------------------------------------------------
  // radio controls
  // -------------------------------------------------------------
  reg [1:0] next_rate;

  always @*
  begin
    // RL9 low rate wins
    if (low_rate_select)
      next_rate = `RLS_RATE_250K;
    // RL8 rate pair decode
    else if (high_rate_select)
      next_rate = `RLS_RATE_2M;
    else
      next_rate = `RLS_RATE_1M;
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      radio_channel_out      <= `RLS_CHAN_RST;
      continuous_carrier_out <= 1'b0;
      rate_select            <= `RLS_RATE_2M;
      pll_lock_status        <= 1'b0;
      tx_power_out           <= `RLS_POWER_RST;
      tx_power_enable        <= 1'b0;
    end
    else
    begin
      // RL6 tune to channel
      radio_channel_out      <= radio_channel;
      // RL7 continuous carrier drive
      continuous_carrier_out <= continuous_carrier;
      rate_select            <= next_rate;
      // RL10 forced lock
      pll_lock_status        <= pll_lock_raw | force_lock;
      // RL11 power in transmit
      tx_power_out           <= tx_power_level;
      tx_power_enable        <= tx_mode | continuous_carrier;
    end
  end

  // -------------------------------------------------------------
  // retransmission
  // -------------------------------------------------------------
  wire pipe_acked = (tx_pipe < 3'h6) ? auto_ack_enables[tx_pipe] : 1'b0;

  // RL4 RL5 RL14 RL15 retry engine
  rls_retx_engine #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_retx (
    .clk                 (clk),
    .reset               (reset),
    .delay_code          (retransmit_delay),
    .count_code          (retransmit_count),
    .ack_required        (pipe_acked),
    .new_packet          (new_packet),
    .tx_end              (tx_end),
    .ack_received        (ack_received),
    .ack_failed          (ack_failed),
    .clear_lost          (wr_chan),
    .retx_start          (retx_start),
    .retx_exhausted      (retx_exhausted),
    .retx_done_count     (retx_done_count),
    .lost_packet_counter (lost_packet_counter)
  );

endmodule // rls_setup_regs

`default_nettype wire

/* File: sim/rls_setup_regs_properties.sv */
// timing checks on the radio link setup register ports
// assumes binding into rls_setup_regs, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none

module rls_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [4:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [39:0] stored_address,
  input wire logic        tx_mode,
  input wire logic [39:0] active_address,
  input wire logic [2:0]  addr_width_bytes,
  input wire logic [6:0]  radio_channel_out,
  input wire logic [1:0]  rate_select,
  input wire logic        pll_lock_status,
  input wire logic        continuous_carrier_out,
  input wire logic        tx_power_enable,
  input wire logic [3:0]  lost_packet_counter
);
  logic [39:0] keep;
  assign keep = addr_width_bytes == 3'h3 ? 40'hff_ffff :
                addr_width_bytes == 3'h4 ? 40'hff_ffff_ffff >> 8 :
                40'hff_ffff_ffff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_RDATA_HOLDS: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property ((reg_read &&
    (reg_addr < 5'h03 || reg_addr > 5'h06)) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RESERVED_ZERO: assert property (reg_read |=>
    (reg_rdata & ($past(reg_addr) == 5'h03 ? 8'hfc :
    $past(reg_addr) == 5'h05 ? 8'h80 :
    $past(reg_addr) == 5'h06 ? 8'h40 : 8'h00)) == 8'h00)
    else $error("reserved bit read as one");
  AST_ADDR_MASK: assert property (!$past(reset) |->
    active_address == ($past(stored_address) & keep))
    else $error("address bytes beyond width not dropped");
  AST_WIDTH_CODE: assert property ((reg_write && reg_addr == 5'h03 &&
    reg_wdata[1:0] != 2'h0) |=> ##1
    addr_width_bytes == {1'b0, $past(reg_wdata[1:0], 2)} + 3'h2)
    else $error("address width not from code");
  AST_RATE_MAP: assert property ((reg_write && reg_addr == 5'h06)
    |=> ##1 rate_select == ($past(reg_wdata[5], 2) ? 2'h2 :
    {1'b0, $past(reg_wdata[3], 2)}))
    else $error("data rate not from rate bits");
  AST_FORCE_LOCK: assert property ((reg_write && reg_addr == 5'h06 &&
    reg_wdata[4]) |=> ##1 pll_lock_status)
    else $error("forced lock not shown");
  AST_POWER_ENABLE: assert property (!$past(reset) |->
    tx_power_enable == ($past(tx_mode) | continuous_carrier_out))
    else $error("power enable wrong");
  AST_CHAN_FOLLOW: assert property ((reg_write && reg_addr == 5'h05)
    |=> ##1 radio_channel_out == $past(reg_wdata[6:0], 2))
    else $error("channel output wrong");
  AST_LOST_CLEAR: assert property ((reg_write && reg_addr == 5'h05)
    |=> lost_packet_counter == 4'h0)
    else $error("channel write kept lost count");
  AST_LOST_SATURATES: assert property (lost_packet_counter == 4'hf
    |=> lost_packet_counter inside {4'h0, 4'hf})
    else $error("lost count wrapped");
endmodule // rls_props

bind rls_setup_regs rls_props i_rls_props (.*);

`default_nettype wire

/* File: sim/rls_cmd_master.sv */
// controller model issuing register commands
// assumes strobes taken on the rising clk edge
`timescale 1ns/1ps
`default_nettype none

module rls_cmd_master #(
  parameter int IDLE = 0
) (
  input  wire logic       clk,
  output var  logic [4:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_write,
  output var  logic       reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    repeat (IDLE) @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    repeat (IDLE) @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule // rls_cmd_master

`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the radio link setup registers
// assumes the command master model drives the register port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  wire  [4:0]  reg_addr;
  wire  [7:0]  reg_wdata;
  wire         reg_write;
  wire         reg_read;
  wire  [7:0]  reg_rdata;
  logic [39:0] stored_address = 40'h11_2233_4455;
  logic [5:0]  auto_ack_enables = 6'h3f;
  logic [2:0]  tx_pipe = 3'h0;
  logic        tx_mode = 1'b0;
  logic        pll_lock_raw = 1'b0;
  logic        new_packet = 1'b0;
  logic        tx_end = 1'b0;
  logic        ack_received = 1'b0;
  logic        ack_failed = 1'b0;
  wire  [39:0] active_address;
  wire  [2:0]  addr_width_bytes;
  wire  [6:0]  radio_channel_out;
  wire         continuous_carrier_out;
  wire  [1:0]  rate_select;
  wire         pll_lock_status;
  wire  [1:0]  tx_power_out;
  wire         tx_power_enable;
  wire         retx_start;
  wire         retx_exhausted;
  wire  [3:0]  retx_done_count;
  wire  [3:0]  lost_packet_counter;
  int          errors = 0;
  int          samples_checked = 0;
  int          n;
  logic [7:0]  rd;
  logic [7:0]  rs [4] = '{8'h00, 8'h0a, 8'h24, 8'h3e};
  logic [1:0]  ex [4] = '{2'h0, 2'h1, 2'h2, 2'h2};

  always #12.5 clk = ~clk;

  rls_setup_regs #(.STEP_CYCLES(18'd4)) i_rls_setup_regs (.*);
  rls_cmd_master i_rls_cmd_master (.*);

  task automatic ck(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    i_rls_cmd_master.rd_reg(a, rd);
    ck(rd, e);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_rls_cmd_master.wr_reg(a, d);
  endtask

  task automatic send(input logic f);
    @(posedge clk);
    new_packet <= f;
    @(posedge clk);
    new_packet <= 1'b0;
    tx_end <= 1'b1;
    @(posedge clk);
    tx_end <= 1'b0;
    ack_failed <= 1'b1;
    @(posedge clk);
    ack_failed <= 1'b0;
  endtask

  task automatic wait_pulse(input logic w, input int e);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (n < 40 && (w ? retx_exhausted : retx_start) !== 1'b1);
    ck(40'(n), 40'(e));
    if (n >= 40)
      tally_and_finish();
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rchk(5'h03, 8'h03);
    rchk(5'h04, 8'h03);
    rchk(5'h05, 8'h02);
    rchk(5'h06, 8'h0e);
    ck(rate_select, 2'h1);
    for (int c = 1; c < 4; c++)
    begin
      wr(5'h03, 8'hfc | c[7:0]);
      rchk(5'h03, c[7:0]);
      ck(addr_width_bytes, 40'(c + 2));
      ck(active_address,
         stored_address & (40'hff_ffff_ffff >> (24 - 8 * c)));
    end
    wr(5'h03, 8'h00);
    rchk(5'h03, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h06, rs[i]);
      rchk(5'h06, rs[i]);
      ck(rate_select, ex[i]);
      ck(tx_power_out, rs[i][2:1]);
      ck(pll_lock_status, rs[i][4]);
    end
    wr(5'h06, 8'hc0);
    rchk(5'h06, 8'h80);
    ck({continuous_carrier_out, tx_power_enable}, 2'h3);
    @(posedge clk) tx_mode <= 1'b1;
    wr(5'h06, 8'h00);
    rchk(5'h07, 8'h00);
    ck(tx_power_enable, 1'b1);
    // real lock must still pass with force bit low
    pll_lock_raw <= 1'b1;
    wr(5'h07, 8'hff);
    rchk(5'h07, 8'h00);
    ck(pll_lock_status, 1'b1);
    wr(5'h04, 8'h01);
    send(1'b1);
    wait_pulse(1'b0, 4);
    ck(retx_done_count, 4'h1);
    send(1'b0);
    wait_pulse(1'b1, 4);
    wr(5'h04, 8'h20);
    rchk(5'h04, 8'h20);
    send(1'b1);
    wait_pulse(1'b1, 12);
    wr(5'h04, 8'h00);
    repeat (14)
    begin
      send(1'b1);
      wait_pulse(1'b1, 4);
    end
    ck(lost_packet_counter, 4'hf);
    auto_ack_enables <= 6'h3d;
    tx_pipe <= 3'h1;
    send(1'b1);
    repeat (20)
    begin
      @(posedge clk);
      ck({retx_start, retx_exhausted}, 2'h0);
    end
    // acknowledge ends the wait, a later stray failure is ignored
    auto_ack_enables <= 6'h3f;
    @(posedge clk);
    tx_end <= 1'b1;
    @(posedge clk);
    tx_end <= 1'b0;
    ack_received <= 1'b1;
    @(posedge clk);
    ack_received <= 1'b0;
    ack_failed <= 1'b1;
    @(posedge clk);
    ack_failed <= 1'b0;
    repeat (20)
    begin
      @(posedge clk);
      ck({retx_start, retx_exhausted}, 2'h0);
    end
    wr(5'h05, 8'h10);
    ck(lost_packet_counter, 4'h0);
    rchk(5'h05, 8'h10);
    ck(radio_channel_out, 7'h10);
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
